/* File: verilog/ccr_map.svh */
/*
 * Register offsets, field positions, reset values and timing counts of the
 * clock-chip configuration register bank.
 * Assumes a 12-bit register address supplied by the serial port engine.
 */
`ifndef CCR_MAP_SVH
`define CCR_MAP_SVH

`define CCR_ADDR_W        12
`define CCR_ADDR_CFG      12'h000
`define CCR_ADDR_RBK      12'h004
`define CCR_ADDR_ID_LO    12'h005
`define CCR_ADDR_ID_HI    12'h006
`define CCR_ADDR_RA_LO    12'h010
`define CCR_ADDR_RA_HI    12'h011
`define CCR_ADDR_RB_LO    12'h012
`define CCR_ADDR_RB_HI    12'h013

`define CCR_CFG_SDO_HI    7
`define CCR_CFG_LSB_HI    6
`define CCR_CFG_SRST_HI   5
`define CCR_CFG_SRST_LO   2
`define CCR_CFG_LSB_LO    1
`define CCR_CFG_SDO_LO    0
`define CCR_RBK_ACTIVE    0

`define CCR_RST_BYTE      8'h00
`define CCR_RST_ID        16'h0000
`define CCR_RST_DIV       10'h000
`define CCR_SRST_CYCLES   1

`endif

/* File: verilog/ccr_pkg.sv */
/*
 * Types shared by the clock-chip configuration register bank.
 * Assumes ccr_map.svh is on the include path.
 */
`include "ccr_map.svh"

package ccr_pkg;
    typedef logic [`CCR_ADDR_W-1:0] ccr_addr_t;
    typedef logic [7:0]             ccr_byte_t;
    typedef logic [15:0]            ccr_id_t;
    typedef logic [9:0]             ccr_div_t;
endpackage : ccr_pkg

/* File: verilog/ccr_regbank.sv */
/*
 * Configuration register bank of a jitter-cleaner clock chip: serial port
 * configuration, readback select, customer version word and the input PLL
 * reference dividers; only the version word and dividers have buffered and active copies.
 * Assumes the serial port engine on sys_clk presents byte accesses and
 * the i2c_mode level; io_update transfers buffered values to active ones.
 */

`include "ccr_map.svh"

module ccr_regbank
    import ccr_pkg::*;
(
    input  wire logic      sys_clk,
    input  wire logic      arst_n,
    input  wire logic      i2c_mode,
    input  wire logic      wr_en,
    input  wire logic      rd_en,
    input  wire ccr_addr_t addr,
    input  wire ccr_byte_t wr_data,
    input  wire logic      io_update,
    output ccr_byte_t      rd_data,
    output logic           sdo_active,
    output logic           lsb_first_incr,
    output logic           soft_reset,
    output logic           readback_active,
    output ccr_id_t        customer_id,
    output ccr_div_t       ref_input_a_div,
    output ccr_div_t       ref_input_b_div
);

    function automatic logic ccr_pair(input ccr_byte_t d, input int hi,
                                      input int lo);
        return d[hi] | d[lo];
    endfunction : ccr_pair

    logic      sdo_r;
    logic      lsb_r;
    logic      srst_r;
    logic      rbk_r;
    ccr_id_t   id_buf_r;
    ccr_id_t   id_act_r;
    ccr_div_t  ra_buf_r;
    ccr_div_t  ra_act_r;
    ccr_div_t  rb_buf_r;
    ccr_div_t  rb_act_r;
    ccr_byte_t rd_data_r;

    wire logic hit_cfg   = (addr == `CCR_ADDR_CFG);
    wire logic hit_rbk   = (addr == `CCR_ADDR_RBK);
    wire logic hit_id_lo = (addr == `CCR_ADDR_ID_LO);
    wire logic hit_id_hi = (addr == `CCR_ADDR_ID_HI);
    wire logic hit_ra_lo = (addr == `CCR_ADDR_RA_LO);
    wire logic hit_ra_hi = (addr == `CCR_ADDR_RA_HI);
    wire logic hit_rb_lo = (addr == `CCR_ADDR_RB_LO);
    wire logic hit_rb_hi = (addr == `CCR_ADDR_RB_HI);
    wire logic hit_any   = hit_cfg | hit_rbk | hit_id_lo | hit_id_hi |
                           hit_ra_lo | hit_ra_hi | hit_rb_lo | hit_rb_hi;
    // Write strobe is gated by soft reset only; unmapped addresses hit no register
    wire logic wr_ok     = wr_en & ~srst_r;

    // Either bit of a mirrored pair sets the field, except the SDO and LSB-first fields in I2C mode
    wire logic sdo_nxt  = ~i2c_mode &
        ccr_pair(wr_data, `CCR_CFG_SDO_HI, `CCR_CFG_SDO_LO);
    wire logic lsb_nxt  = ~i2c_mode &
        ccr_pair(wr_data, `CCR_CFG_LSB_HI, `CCR_CFG_LSB_LO);
    wire logic srst_nxt =
        ccr_pair(wr_data, `CCR_CFG_SRST_HI, `CCR_CFG_SRST_LO);

    wire ccr_id_t id_buf_nxt = {
        (wr_ok & hit_id_hi) ? wr_data : id_buf_r[15:8],
        (wr_ok & hit_id_lo) ? wr_data : id_buf_r[7:0]};
    wire ccr_div_t ra_buf_nxt = {
        (wr_ok & hit_ra_hi) ? wr_data[1:0] : ra_buf_r[9:8],
        (wr_ok & hit_ra_lo) ? wr_data : ra_buf_r[7:0]};
    wire ccr_div_t rb_buf_nxt = {
        (wr_ok & hit_rb_hi) ? wr_data[1:0] : rb_buf_r[9:8],
        (wr_ok & hit_rb_lo) ? wr_data : rb_buf_r[7:0]};

    // Readback view picks active or buffered copies
    wire ccr_id_t  id_view = rbk_r ? id_act_r : id_buf_r;
    wire ccr_div_t ra_view = rbk_r ? ra_act_r : ra_buf_r;
    wire ccr_div_t rb_view = rbk_r ? rb_act_r : rb_buf_r;

    wire ccr_byte_t cfg_view = {sdo_r, lsb_r, srst_r, 2'b00,
                                srst_r, lsb_r, sdo_r};
    wire ccr_byte_t rd_mux =
        hit_cfg   ? cfg_view :
        hit_rbk   ? {7'h00, rbk_r} :
        hit_id_lo ? id_view[7:0] :
        hit_id_hi ? id_view[15:8] :
        hit_ra_lo ? ra_view[7:0] :
        hit_ra_hi ? {6'h00, ra_view[9:8]} :
        hit_rb_lo ? rb_view[7:0] :
        hit_rb_hi ? {6'h00, rb_view[9:8]} : `CCR_RST_BYTE;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sdo_r     <= 1'b0;
            lsb_r     <= 1'b0;
            srst_r    <= 1'b0;
            rbk_r     <= 1'b0;
            id_buf_r  <= `CCR_RST_ID;
            id_act_r  <= `CCR_RST_ID;
            ra_buf_r  <= `CCR_RST_DIV;
            ra_act_r  <= `CCR_RST_DIV;
            rb_buf_r  <= `CCR_RST_DIV;
            rb_act_r  <= `CCR_RST_DIV;
            rd_data_r <= `CCR_RST_BYTE;
        end else if (srst_r) begin
            // Soft reset restores defaults and clears its request
            sdo_r     <= 1'b0;
            lsb_r     <= 1'b0;
            srst_r    <= 1'b0;
            rbk_r     <= 1'b0;
            id_buf_r  <= `CCR_RST_ID;
            id_act_r  <= `CCR_RST_ID;
            ra_buf_r  <= `CCR_RST_DIV;
            ra_act_r  <= `CCR_RST_DIV;
            rb_buf_r  <= `CCR_RST_DIV;
            rb_act_r  <= `CCR_RST_DIV;
            rd_data_r <= `CCR_RST_BYTE;
        end else begin
            if (wr_ok && hit_cfg) begin
                sdo_r  <= sdo_nxt;
                lsb_r  <= lsb_nxt;
                srst_r <= srst_nxt;
            end
            if (wr_ok && hit_rbk) begin
                rbk_r <= wr_data[`CCR_RBK_ACTIVE];
            end
            id_buf_r <= id_buf_nxt;
            ra_buf_r <= ra_buf_nxt;
            rb_buf_r <= rb_buf_nxt;
            if (io_update) begin
                id_act_r <= id_buf_r;
                ra_act_r <= ra_buf_r;
                rb_act_r <= rb_buf_r;
            end
            if (rd_en) begin
                rd_data_r <= rd_mux;
            end
        end
    end

    assign rd_data         = rd_data_r;
    assign sdo_active      = sdo_r & ~i2c_mode;
    assign lsb_first_incr  = lsb_r & ~i2c_mode;
    assign soft_reset      = srst_r;
    assign readback_active = rbk_r;
    assign customer_id     = id_act_r;
    assign ref_input_a_div = ra_act_r;
    assign ref_input_b_div = rb_act_r;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    chk_unmapped_no_change: assert property (
        wr_en && !hit_any && !srst_r && !io_update |=>
            $stable(id_buf_r) && $stable(ra_buf_r) && $stable(rb_buf_r) &&
            $stable(sdo_r) && $stable(lsb_r) && $stable(rbk_r) && !srst_r)
        else $error("unmapped write changed state");

    chk_cfg_mirror_read: assert property (
        rd_en && hit_cfg && !srst_r |=>
            rd_data[7] == rd_data[0] && rd_data[6] == rd_data[1] &&
            rd_data[5] == rd_data[2] && rd_data[4:3] == 2'b00)
        else $error("config readback not mirrored");

    chk_cfg_i2c_gate: assert property (
        wr_en && hit_cfg && !srst_r && i2c_mode |=> !sdo_r && !lsb_r)
        else $error("SPI-only bits set in I2C mode");

    chk_rbk_active_view: assert property (
        rd_en && hit_ra_lo && rbk_r && !srst_r |=>
            rd_data == $past(ra_act_r[7:0]))
        else $error("active readback returned buffered value");

    chk_id_low_store: assert property (
        wr_en && hit_id_lo && !srst_r |=> id_buf_r[7:0] == $past(wr_data))
        else $error("customer id low byte not stored");

    chk_id_high_store: assert property (
        wr_en && hit_id_hi && !srst_r |=> id_buf_r[15:8] == $past(wr_data))
        else $error("customer id high byte not stored");

    chk_ra_top_bits: assert property (
        rd_en && hit_ra_hi && !rbk_r && !srst_r |=>
            rd_data == {6'h00, $past(ra_buf_r[9:8])})
        else $error("ref A top bits wrong");

    chk_rb_low_store: assert property (
        wr_en && hit_rb_lo && !srst_r |=>
            rb_buf_r[7:0] == $past(wr_data))
        else $error("ref B low byte not stored");

    chk_rb_top_bits: assert property (
        wr_en && hit_rb_hi && !srst_r |=> rb_buf_r[9:8] == $past(wr_data[1:0]))
        else $error("ref B top bits not stored");

    chk_srst_self_clear: assert property (
        wr_en && hit_cfg && !srst_r && srst_nxt |=> soft_reset ##1
            (!soft_reset && id_buf_r == `CCR_RST_ID &&
             ra_act_r == `CCR_RST_DIV && !sdo_r && !rbk_r))
        else $error("soft reset did not restore defaults");

    cov_soft_reset:   cover property (wr_en && hit_cfg && srst_nxt && !srst_r);
    cov_io_update:    cover property (io_update && ra_buf_r != ra_act_r);
    cov_active_read:  cover property (rd_en && rbk_r && hit_rb_lo);
    cov_unmapped_wr:  cover property (wr_en && !hit_any);

endmodule : ccr_regbank

/* File: verification/ccr_host.sv */
/*
 * Host model: the serial engine that reaches the register bank.
 * Assumes sys_clk from the bench; requests change on the falling edge.
 */
module ccr_host
    import ccr_pkg::*;
(
    input  wire logic sys_clk,
    output logic      wr_en,
    output logic      rd_en,
    output ccr_addr_t addr,
    output ccr_byte_t wr_data
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 12'h000;
        wr_data = 8'h00;
    end

    // Reserved bit positions of 0x004, 0x011 and 0x013 carry their defaults
    function automatic ccr_byte_t keep(ccr_addr_t a, ccr_byte_t d);
        case (a)
            12'h004: return d & 8'h01;
            12'h011, 12'h013: return d & 8'h03;
            default: return d;
        endcase
    endfunction : keep

    // Wholly reserved registers such as 0x001 and 0x007 may be addressed, with data unmasked
    task automatic acc(input logic w, input ccr_addr_t a, input ccr_byte_t d);
        @(negedge sys_clk);
        wr_en = w;
        rd_en = !w;
        addr = a;
        wr_data = keep(a, d);
        @(negedge sys_clk);
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = ~a;
        wr_data = ~wr_data;
    endtask : acc
endmodule : ccr_host

/* File: verification/ccr_regbank_test.sv */
/*
 * Self-checking bench of the register bank with a host model.
 * Assumes ccr_pkg, ccr_regbank and ccr_host are compiled first.
 */
module ccr_regbank_test;
    timeunit 1ns;
    timeprecision 1ps;
    import ccr_pkg::*;

    logic        sys_clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        i2c_mode = 1'b0;
    logic        io_update = 1'b0;
    logic        rd_seen = 1'b0;
    logic        wr_en, rd_en, sdo_active, lsb_first_incr;
    logic        soft_reset, readback_active;
    ccr_addr_t   addr;
    ccr_byte_t   wr_data, rd_data;
    ccr_id_t     customer_id;
    ccr_div_t    ref_input_a_div, ref_input_b_div;
    int          num_errors = 0;
    int          comparisons = 0;
    int          cycles = 0;
    logic [31:0] seed = 32'h4302;
    ccr_byte_t   exp_q[$];
    ccr_addr_t   map[8] = '{12'h000, 12'h004, 12'h005, 12'h006,
                            12'h010, 12'h011, 12'h012, 12'h013};

    ccr_host ccr_host_i (.sys_clk(sys_clk), .wr_en(wr_en), .rd_en(rd_en),
                         .addr(addr), .wr_data(wr_data));
    ccr_regbank ccr_regbank_i (.sys_clk(sys_clk), .arst_n(arst_n),
        .i2c_mode(i2c_mode), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
        .wr_data(wr_data), .io_update(io_update), .rd_data(rd_data),
        .sdo_active(sdo_active), .lsb_first_incr(lsb_first_incr),
        .soft_reset(soft_reset), .readback_active(readback_active),
        .customer_id(customer_id), .ref_input_a_div(ref_input_a_div),
        .ref_input_b_div(ref_input_b_div));

    always #12.5 sys_clk = ~sys_clk;

    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp

    task automatic cmp_rd();
        cmp({8'h00, rd_data}, {8'h00, exp_q.pop_front()});
    endtask : cmp_rd

    task automatic wr(input ccr_addr_t a, input ccr_byte_t d);
        ccr_host_i.acc(1'b1, a, d);
    endtask : wr

    task automatic rd(input ccr_addr_t a, input ccr_byte_t e);
        exp_q.push_back(e);
        ccr_host_i.acc(1'b0, a, 8'h00);
    endtask : rd

    task automatic upd();
        @(negedge sys_clk);
        io_update = 1'b1;
        @(negedge sys_clk);
        io_update = 1'b0;
    endtask : upd

    task automatic tally_and_finish();
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : tally_and_finish

    // Read results are registered on the taking edge and checked at the next falling edge
    always @(posedge sys_clk) rd_seen <= rd_en;
    always @(negedge sys_clk) begin
        if (rd_seen && exp_q.size() > 0)
            cmp_rd();
    end

    always @(negedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            tally_and_finish();
        end
    end

    initial begin
        ccr_byte_t v[8];
        repeat (12) @(negedge sys_clk);
        arst_n = 1'b1;
        cmp({sdo_active, lsb_first_incr}, 0);
        cmp({soft_reset, readback_active}, 0);
        cmp(customer_id | ref_input_a_div | ref_input_b_div, 0);
        foreach (map[i])
            rd(map[i], 8'h00);
        $display("defaults done");
        for (int i = 2; i < 8; i++) begin
            seed = lfsr(seed);
            v[i] = seed[7:0];
            wr(map[i], v[i]);
        end
        wr(12'h001, 8'hff);
        wr(12'h007, 8'hff);
        for (int i = 2; i < 8; i++)
            rd(map[i], (i == 5 || i == 7) ? v[i] & 8'h03 : v[i]);
        rd(12'h007, 8'h00);
        wr(12'h004, 8'h01);
        cmp(readback_active, 1);
        rd(12'h010, 8'h00);
        upd();
        rd(12'h010, v[4]);
        cmp(customer_id, {v[3], v[2]});
        cmp(ref_input_a_div, {v[5][1:0], v[4]});
        cmp(ref_input_b_div, {v[7][1:0], v[6]});
        $display("dividers done");
        wr(12'h000, 8'h01);
        cmp({sdo_active, lsb_first_incr}, 2'b10);
        rd(12'h000, 8'h81);
        wr(12'h000, 8'h40);
        cmp({sdo_active, lsb_first_incr}, 2'b01);
        rd(12'h000, 8'h42);
        i2c_mode = 1'b1;
        #1;
        cmp({sdo_active, lsb_first_incr}, 2'b00);
        $display("serial config done");
        for (int k = 0; k < 2; k++) begin
            i2c_mode = k[0];
            wr(12'h000, k ? 8'h20 : 8'h04);
            cmp(soft_reset, 1);
            @(negedge sys_clk);
            cmp({soft_reset, readback_active}, 0);
            cmp(customer_id | ref_input_a_div | ref_input_b_div, 0);
            rd(12'h000, 8'h00);
            rd(12'h010, 8'h00);
            wr(12'h010, 8'h5a);
            upd();
        end
        repeat (3) @(negedge sys_clk);
        $display("soft reset done");
        tally_and_finish();
    end
endmodule : ccr_regbank_test
